// ### rtl/srsp_pkg.sv
// Package of resource identifiers, policy codes and sizing constants.
package srsp_pkg;

   // ----------------------------------------------------------------------
   // Sharing policies
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      SRSP_POL_SHARED,
      SRSP_POL_WATERMARK,
      SRSP_POL_PARTITION
   } srsp_policy_e;

   // ----------------------------------------------------------------------
   // Resource indices
   // ----------------------------------------------------------------------
   localparam int SRSP_NUM_RES = 18;
   localparam int SRSP_RES_ICACHE = 0;
   localparam int SRSP_RES_ITLB = 1;
   localparam int SRSP_RES_OPCACHE = 2;
   localparam int SRSP_RES_DISPATCH = 3;
   localparam int SRSP_RES_DCACHE = 4;
   localparam int SRSP_RES_DTLB = 5;
   localparam int SRSP_RES_L2 = 6;
   localparam int SRSP_RES_L3 = 7;
   localparam int SRSP_RES_INT_SCHED = 8;
   localparam int SRSP_RES_INT_REGS = 9;
   localparam int SRSP_RES_LOAD_Q = 10;
   localparam int SRSP_RES_FP_REGS = 11;
   localparam int SRSP_RES_FP_SCHED = 12;
   localparam int SRSP_RES_MEM_REQ = 13;
   localparam int SRSP_RES_OP_Q = 14;
   localparam int SRSP_RES_STORE_Q = 15;
   localparam int SRSP_RES_WRITE_MERGE = 16;
   localparam int SRSP_RES_RETIRE_Q = 17;

   // ----------------------------------------------------------------------
   // Sizing and reset values
   // ----------------------------------------------------------------------
   localparam int SRSP_ENTRY_W = 8;
   localparam logic [SRSP_ENTRY_W-1:0] SRSP_ENTRIES_DEF = 8'h40;
   localparam logic [SRSP_ENTRY_W-1:0] SRSP_WATERMARK_DEF = 8'h30;
   localparam logic [SRSP_ENTRY_W:0] SRSP_CNT_RST = 9'h000;
   localparam logic SRSP_RR_RST = 1'b0;

   // Fixed policy of each resource; the third-level cache entry is never used,
   // as the top takes that policy from the configuration input.
   function automatic srsp_policy_e srsp_policy_of(input int idx);
      case (idx)
         SRSP_RES_INT_SCHED, SRSP_RES_INT_REGS, SRSP_RES_LOAD_Q,
         SRSP_RES_FP_SCHED, SRSP_RES_MEM_REQ, SRSP_RES_WRITE_MERGE:
            return SRSP_POL_WATERMARK;
         SRSP_RES_OP_Q, SRSP_RES_STORE_Q, SRSP_RES_RETIRE_Q:
            return SRSP_POL_PARTITION;
         default:
            return SRSP_POL_SHARED;
      endcase
   endfunction : srsp_policy_of

endpackage : srsp_pkg

// ### rtl/srsp_slot.sv
// One shared resource: per-thread occupancy counters and grant decision.
`timescale 1ns/1ns
`default_nettype none

module srsp_slot
   import srsp_pkg::*;
#(
   parameter int ENTRY_W = SRSP_ENTRY_W
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic dual_thread_mode,
   input wire srsp_policy_e policy,
   input wire logic [ENTRY_W-1:0] entries,
   input wire logic [ENTRY_W-1:0] watermark,
   input wire logic [1:0] req,
   input wire logic [1:0] rel,
   input wire logic [1:0] stalled,
   output logic [1:0] grant_q,
   output logic [ENTRY_W:0] held0_q,
   output logic [ENTRY_W:0] held1_q
);

   // ----------------------------------------------------------------------
   // Partition capture and arbitration state
   // ----------------------------------------------------------------------
   logic dual_prev_q;
   logic dual_prev_d;
   logic [ENTRY_W:0] part0_q;
   logic [ENTRY_W:0] part0_d;
   logic rr_q;
   logic rr_d;
   logic [1:0] grant_d;
   logic [ENTRY_W:0] held0_d;
   logic [ENTRY_W:0] held1_d;
   logic [ENTRY_W:0] total;
   logic [ENTRY_W:0] cap0;
   logic [ENTRY_W:0] cap1;
   logic [1:0] fits;
   logic [1:0] ok;
   localparam logic [ENTRY_W:0] CNT_RST = (ENTRY_W+1)'(SRSP_CNT_RST);

   always_comb begin
      dual_prev_d = dual_thread_mode;
      part0_d = part0_q;
      // Partitions are cut only on entry to dual-thread mode.
      if (dual_thread_mode && !dual_prev_q) begin
         part0_d = {1'b0, entries} >> 1;
      end
   end

   always_comb begin
      total = held0_q + held1_q;
      cap0 = {1'b0, entries};
      cap1 = {1'b0, entries};
      if (dual_thread_mode) begin
         case (policy)
            SRSP_POL_WATERMARK: begin
               cap0 = {1'b0, watermark};
               cap1 = {1'b0, watermark};
            end
            SRSP_POL_PARTITION: begin
               // The split lands one cycle after entry; refuse until then.
               cap0 = dual_prev_q ? part0_q : '0;
               cap1 = dual_prev_q ? {1'b0, entries} - part0_q : '0;
            end
            default: begin
               cap0 = {1'b0, entries};
               cap1 = {1'b0, entries};
            end
         endcase
      end
      // A thread may only take one entry per cycle, so the check is +1.
      fits[0] = (held0_q < cap0) && (total < {1'b0, entries});
      fits[1] = (held1_q < cap1) && (total < {1'b0, entries});
      ok = req & fits;
      grant_d = 2'b00;
      rr_d = rr_q;
      if (policy == SRSP_POL_PARTITION && dual_thread_mode) begin
         // One slot per cycle; a stalled thread yields it to the other.
         ok = ok & ~stalled;
         if (ok == 2'b11) begin
            grant_d = rr_q ? 2'b10 : 2'b01;
            rr_d = ~rr_q;
         end else if (ok != 2'b00) begin
            grant_d = ok;
            rr_d = ok[0];
         end
      end else if (ok == 2'b11 && total + 1'b1 >= {1'b0, entries}) begin
         // Only one entry left: alternate who gets it.
         grant_d = rr_q ? 2'b10 : 2'b01;
         rr_d = ~rr_q;
      end else begin
         grant_d = ok;
      end
      held0_d = held0_q + {{ENTRY_W{1'b0}}, grant_d[0]};
      held1_d = held1_q + {{ENTRY_W{1'b0}}, grant_d[1]};
      if (rel[0] && held0_d != CNT_RST) begin
         held0_d = held0_d - 1'b1;
      end
      if (rel[1] && held1_d != CNT_RST) begin
         held1_d = held1_d - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         dual_prev_q <= 1'b0;
         part0_q <= CNT_RST;
         rr_q <= SRSP_RR_RST;
         grant_q <= 2'b00;
         held0_q <= CNT_RST;
         held1_q <= CNT_RST;
      end else if (clk_en) begin
         dual_prev_q <= dual_prev_d;
         part0_q <= part0_d;
         rr_q <= rr_d;
         grant_q <= grant_d;
         held0_q <= held0_d;
         held1_q <= held1_d;
      end
   end

endmodule : srsp_slot

`default_nettype wire

// ### rtl/srsp_top.sv
// Resource sharing policy block for a two-thread core, one slot per resource.
`timescale 1ns/1ns
`default_nettype none

// Operation
// - Shared resources grant any asker; one thread may hold every entry.
// - Watermark resources cap each thread at the watermark in dual mode.
// - Partitions are cut on entering dual mode; threads stay in their own.
// - Partitioned resources alternate threads in dual mode, skipping a stalled one.
// - Caches, translation buffers, dispatch and FP registers are shared.
// - Watermark: schedulers, int file, load queue, request, merge buffers.
// - Op queue, store queue and retire queue are statically partitioned.
// - Third-level cache defaults to shared but its policy is configurable.
module srsp_top
   import srsp_pkg::*;
#(
   parameter int NUM_RES = SRSP_NUM_RES,
   parameter int ENTRY_W = SRSP_ENTRY_W,
   parameter logic [ENTRY_W-1:0] ENTRIES = SRSP_ENTRIES_DEF,
   parameter logic [ENTRY_W-1:0] WATERMARK = SRSP_WATERMARK_DEF
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic dual_thread_mode,
   input wire srsp_policy_e l3_policy_cfg,
   input wire logic [NUM_RES-1:0] req_t0,
   input wire logic [NUM_RES-1:0] req_t1,
   input wire logic [NUM_RES-1:0] rel_t0,
   input wire logic [NUM_RES-1:0] rel_t1,
   input wire logic stall_t0,
   input wire logic stall_t1,
   output logic [NUM_RES-1:0] grant_t0,
   output logic [NUM_RES-1:0] grant_t1,
   output logic single_thread_mode
);

   // ----------------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------------
   if (NUM_RES != SRSP_NUM_RES) begin : g_bad_num
      $error("resource count must match the fixed policy table");
   end
   if (ENTRIES < 2 || WATERMARK > ENTRIES) begin : g_bad_size
      $error("need at least two entries and a watermark within them");
   end

   // ----------------------------------------------------------------------
   // Mode flag
   // ----------------------------------------------------------------------
   logic single_q;
   logic single_d;

   always_comb begin
      single_d = !dual_thread_mode;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         single_q <= 1'b1;
      end else if (clk_en) begin
         single_q <= single_d;
      end
   end

   assign single_thread_mode = single_q;

   // ----------------------------------------------------------------------
   // Per-resource slots
   // ----------------------------------------------------------------------
   // The policy of every slot but the third-level cache is wired at build
   // time, so no stray configuration can turn a queue into a shared pool.
   for (genvar i = 0; i < NUM_RES; i++) begin : g_res
      srsp_policy_e pol;
      logic [1:0] gnt;
      if (i == SRSP_RES_L3) begin : g_cfg
         assign pol = l3_policy_cfg;
      end else begin : g_fix
         assign pol = srsp_policy_of(i);
      end
      srsp_slot #(
         .ENTRY_W(ENTRY_W)
      ) u_slot (
         .clk(clk),
         .sys_rst(sys_rst),
         .clk_en(clk_en),
         .dual_thread_mode(dual_thread_mode),
         .policy(pol),
         .entries(ENTRIES),
         .watermark(WATERMARK),
         .req({req_t1[i], req_t0[i]}),
         .rel({rel_t1[i], rel_t0[i]}),
         .stalled({stall_t1, stall_t0}),
         .grant_q(gnt),
         .held0_q(),
         .held1_q()
      );
      assign grant_t0[i] = gnt[0];
      assign grant_t1[i] = gnt[1];
   end

endmodule : srsp_top

`default_nettype wire

// ### tb/srsp_top_properties.sv
// Port-level checker of the resource sharing block.
`timescale 1ns/1ns
`default_nettype none

module srsp_top_checker
   import srsp_pkg::*;
#(
   parameter int NUM_RES = SRSP_NUM_RES
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic dual_thread_mode,
   input wire logic [NUM_RES-1:0] req_t0,
   input wire logic [NUM_RES-1:0] req_t1,
   input wire logic stall_t0,
   input wire logic stall_t1,
   input wire logic [NUM_RES-1:0] grant_t0,
   input wire logic [NUM_RES-1:0] grant_t1,
   input wire logic single_thread_mode
);
   // Op queue, store queue and retire queue.
   localparam logic [NUM_RES-1:0] PART = NUM_RES'(18'h2c000);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   chk_t0_grant_asked: assert property ($past(clk_en) |->
      (grant_t0 & ~$past(req_t0)) == '0) else $error("t0 grant unasked");
   chk_t1_grant_asked: assert property ($past(clk_en) |->
      (grant_t1 & ~$past(req_t1)) == '0) else $error("t1 grant unasked");
   chk_part_one_thread: assert property (
      $past(clk_en && dual_thread_mode) |->
      (grant_t0 & grant_t1 & PART) == '0) else $error("both threads served");
   chk_stall_t0_skip: assert property (
      $past(clk_en && dual_thread_mode && stall_t0) |->
      (grant_t0 & PART) == '0) else $error("stalled t0 served");
   chk_stall_t1_skip: assert property (
      $past(clk_en && dual_thread_mode && stall_t1) |->
      (grant_t1 & PART) == '0) else $error("stalled t1 served");
   chk_single_mode_track: assert property (
      !$past(sys_rst) && $past(clk_en) |->
      single_thread_mode == !$past(dual_thread_mode))
      else $error("single mode flag wrong");
   chk_reset_outputs: assert property ($past(sys_rst) |->
      grant_t0 == '0 && grant_t1 == '0 && single_thread_mode)
      else $error("outputs not reset");
   chk_frozen_grants: assert property (
      !$past(clk_en) && !$past(sys_rst) |->
      $stable(grant_t0) && $stable(grant_t1)) else $error("grant moved frozen");
endmodule : srsp_top_checker

bind srsp_top srsp_top_checker #(.NUM_RES(NUM_RES)) u_checker (
   .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
   .dual_thread_mode(dual_thread_mode), .req_t0(req_t0), .req_t1(req_t1),
   .stall_t0(stall_t0), .stall_t1(stall_t1), .grant_t0(grant_t0),
   .grant_t1(grant_t1), .single_thread_mode(single_thread_mode)
);

`default_nettype wire

// ### tb/srsp_threads.sv
// Model of the two thread contexts: requests one resource, counts grants.
`timescale 1ns/1ns
`default_nettype none

module srsp_threads
   import srsp_pkg::*;
(
   input wire logic clk,
   input wire logic clear,
   input wire logic [1:0] run,
   input wire logic [4:0] sel,
   input wire logic [SRSP_NUM_RES-1:0] grant_t0,
   input wire logic [SRSP_NUM_RES-1:0] grant_t1,
   output logic [SRSP_NUM_RES-1:0] req_t0,
   output logic [SRSP_NUM_RES-1:0] req_t1,
   output logic [7:0] got0,
   output logic [7:0] got1
);
   // A thread keeps asking every cycle, as grants come one entry at a time.
   assign req_t0 = run[0] ? SRSP_NUM_RES'(1) << sel : '0;
   assign req_t1 = run[1] ? SRSP_NUM_RES'(1) << sel : '0;
   always_ff @(posedge clk) begin
      got0 <= clear ? 8'h00 : got0 + {7'h00, grant_t0[sel]};
      got1 <= clear ? 8'h00 : got1 + {7'h00, grant_t1[sel]};
   end
endmodule : srsp_threads

`default_nettype wire

// ### tb/srsp_top_test.sv
// Self-checking testbench of the resource sharing block.
`timescale 1ns/1ns
`default_nettype none

`define CHECK(name, exp, got) begin checks++; if ((got) !== (exp)) begin \
   fail_count++; $display("MISMATCH %s exp %0d got %0d", name, exp, got); \
   end end

module srsp_top_test import srsp_pkg::*;;
   localparam logic [7:0] ENT = 8'h10;
   localparam logic [7:0] WM = 8'h0c;
   localparam logic [7:0] HALF = 8'h08;
   localparam logic [17:0] WM_SET = 18'h13700;
   localparam logic [17:0] PART_SET = 18'h2c000;
   logic clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, dual = 1'b0;
   logic stall_t0 = 1'b0, stall_t1 = 1'b0, clear = 1'b0, single;
   srsp_policy_e l3_cfg = SRSP_POL_SHARED;
   logic [1:0] run = 2'b00;
   logic [4:0] sel = 5'h00;
   logic [17:0] req_t0, req_t1, grant_t0, grant_t1;
   logic [17:0] rel_t0 = 18'h00000, rel_t1 = 18'h00000;
   logic [7:0] got0, got1;
   int fail_count = 0, checks = 0;

   srsp_top #(.ENTRIES(ENT), .WATERMARK(WM)) dut (.clk(clk),
      .sys_rst(sys_rst), .clk_en(clk_en), .dual_thread_mode(dual),
      .l3_policy_cfg(l3_cfg), .req_t0(req_t0), .req_t1(req_t1),
      .rel_t0(rel_t0), .rel_t1(rel_t1), .stall_t0(stall_t0),
      .stall_t1(stall_t1), .grant_t0(grant_t0), .grant_t1(grant_t1),
      .single_thread_mode(single));
   srsp_threads threads (.clk(clk), .clear(clear), .run(run), .sel(sel),
      .grant_t0(grant_t0), .grant_t1(grant_t1), .req_t0(req_t0),
      .req_t1(req_t1), .got0(got0), .got1(got1));

   always #4 clk = ~clk;

   task automatic print_verdict();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : print_verdict

   task automatic restart(input logic two);
      sys_rst = 1'b1;
      repeat (12) @(posedge clk);
      #1 sys_rst = 1'b0;
      dual = two;
      repeat (3) @(posedge clk);
      #1;
      `CHECK("single_thread_mode", !two, single)
   endtask : restart

   task automatic drive(input int n, input logic [1:0] who, input int res);
      clear = 1'b1;
      @(posedge clk);
      #1 clear = 1'b0;
      sel = 5'(res);
      run = who;
      repeat (n) @(posedge clk);
      #1 run = 2'b00;
      repeat (2) @(posedge clk);
      #1;
   endtask : drive

   // Thread 0 fills each resource, then thread 1 takes what is left.
   task automatic policy_sweep(input logic two);
      logic [7:0] cap0, cap1;
      restart(two);
      for (int r = 0; r < SRSP_NUM_RES; r++) begin
         cap0 = !two ? ENT : WM_SET[r] ? WM : PART_SET[r] ? HALF : ENT;
         cap1 = !two ? 8'h00 : WM_SET[r] ? ENT - WM : PART_SET[r] ? HALF : 0;
         drive(int'(ENT) + 4, 2'b01, r);
         `CHECK("t0 held", cap0, got0)
         drive(int'(ENT) + 4, 2'b10, r);
         `CHECK("t1 held", cap1, got1)
      end
   endtask : policy_sweep

   task automatic round_robin();
      restart(1'b1);
      drive(6, 2'b11, SRSP_RES_OP_Q);
      `CHECK("rr t0", 8'h03, got0)
      `CHECK("rr t1", 8'h03, got1)
      stall_t1 = 1'b1;
      drive(6, 2'b11, SRSP_RES_STORE_Q);
      `CHECK("stall t1 t0", 8'h06, got0)
      `CHECK("stall t1 t1", 8'h00, got1)
      stall_t1 = 1'b0;
      stall_t0 = 1'b1;
      drive(6, 2'b11, SRSP_RES_RETIRE_Q);
      `CHECK("stall t0 t0", 8'h00, got0)
      `CHECK("stall t0 t1", 8'h06, got1)
      stall_t0 = 1'b0;
      clk_en = 1'b0;
      drive(6, 2'b01, SRSP_RES_OP_Q);
      clk_en = 1'b1;
      `CHECK("frozen t0", 8'h00, got0)
   endtask : round_robin

   task automatic l3_config();
      l3_cfg = SRSP_POL_WATERMARK;
      restart(1'b1);
      drive(int'(ENT) + 4, 2'b01, SRSP_RES_L3);
      `CHECK("l3 watermark t0", WM, got0)
      l3_cfg = SRSP_POL_PARTITION;
      restart(1'b1);
      drive(int'(ENT) + 4, 2'b01, SRSP_RES_L3);
      `CHECK("l3 partition t0", HALF, got0)
      l3_cfg = SRSP_POL_SHARED;
   endtask : l3_config

   // Freed entries go back to the pool and may be taken again.
   task automatic release_refill();
      restart(1'b1);
      drive(int'(ENT) + 4, 2'b01, SRSP_RES_INT_SCHED);
      drive(int'(ENT) + 4, 2'b10, SRSP_RES_INT_SCHED);
      `CHECK("rel pool t1", ENT - WM, got1)
      rel_t0[SRSP_RES_INT_SCHED] = 1'b1;
      rel_t1[SRSP_RES_INT_SCHED] = 1'b1;
      repeat (4) @(posedge clk);
      #1 rel_t0 = 18'h00000;
      rel_t1 = 18'h00000;
      drive(int'(ENT) + 4, 2'b01, SRSP_RES_INT_SCHED);
      `CHECK("rel refill t0", 8'h04, got0)
      drive(int'(ENT) + 4, 2'b10, SRSP_RES_INT_SCHED);
      `CHECK("rel refill t1", 8'h04, got1)
   endtask : release_refill

   initial begin
      policy_sweep(1'b0);
      policy_sweep(1'b1);
      round_robin();
      l3_config();
      release_refill();
      print_verdict();
   end

   initial begin
      #400000;
      fail_count++;
      print_verdict();
   end
endmodule : srsp_top_test

`default_nettype wire
